//--- design/quh_top.sv
// quad uart host status pins, processor strobe port and wishbone registers
// Behaviour
// - processor mode merges all four channel interrupts onto one line
// - in processor mode combined interrupt low while any channel has an enabled source pending
// - infrared output carries the framed serial character as pulses
// - infrared output low in reset, when idle and when transmitter off
// - modem control bit 6 picks modem serial or infrared interface
// - with music clock the serial pins act as music ports
// - in pc mode a high reset pin resets registers and outputs
// - during reset serial transmit and receive stay disabled
// - in processor mode the reset pin is active low
// - strobe falling edge writes cpu byte to addressed register
// - strobe rising edge drives addressed register onto data bus
// - combined receive ready low while any channel holds a character
// - channel receive ready low when characters reach the trigger level
// - channel receive ready high when empty or below trigger level
// - combined transmit ready low while any channel has a free slot
// - combined transmit ready high when no channel has room, and during reset
// - pc mode gives per-channel high interrupts gated by modem bit 3
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
module quh_top (
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_bus_mode_pc,
  input  wire logic                       i_reset_pin,
  input  wire logic                       i_wb_cyc,
  input  wire logic                       i_wb_stb,
  input  wire logic                       i_wb_we,
  input  wire logic [7:0]                 i_wb_adr,
  input  wire logic [3:0]                 i_wb_sel,
  input  wire logic [31:0]                i_wb_dat,
  output logic      [31:0]                o_wb_dat,
  output logic                            o_wb_ack,
  output logic                            o_irq,
  input  wire logic                       i_cs_n,
  input  wire logic                       i_rw_strobe,
  input  wire logic [4:0]                 i_reg_address,
  input  wire logic [7:0]                 i_cpu_data,
  output logic      [7:0]                 o_cpu_data,
  output logic                            o_cpu_data_oe,
  input  wire quh_pkg::quh_chan_in_t [3:0] i_chan,
  input  wire logic                       i_tick16,
  input  wire logic                       i_music_link_clock,
  input  wire logic [3:0]                 i_serial_rx_in,
  output logic      [3:0]                 o_music_rx,
  output logic                            o_irq_any_n,
  output logic      [3:0]                 o_irq_chan,
  output logic                            o_rx_ready_any_n,
  output logic      [3:0]                 o_rx_ready_chan_n,
  output logic                            o_tx_ready_any_n,
  output logic      [3:0]                 o_serial_tx_out,
  output logic      [3:0]                 o_rx_enable,
  output logic      [3:0]                 o_infrared_tx_out
);
  quh_pkg::quh_state_t q, d;
  logic       pin_rst;
  logic       clr;
  logic [3:0] svc;
  logic [3:0] rx_av;
  logic [3:0] tx_sp;
  logic [3:0] ir_en;
  logic       music_rise;

  // read decode, shared by the wishbone slave and the strobe port
  function automatic logic [7:0] rd_reg(input quh_pkg::quh_state_t s,
                                        input quh_pkg::quh_chan_in_t [3:0] ch,
                                        input logic [4:0] idx);
    logic [1:0] c;
    c = idx[4:3];
    rd_reg = 8'h00;
    if (idx == quh_pkg::IDX_EVT) begin
      rd_reg = s.evt;
    end else if (idx == quh_pkg::IDX_MSK) begin
      rd_reg = s.msk;
    end else if (idx[2] == 1'b0) begin
      case (idx[2:0])
        quh_pkg::OFS_IER:  rd_reg = s.irq_enable_reg[c];
        quh_pkg::OFS_MCR:  rd_reg = s.modem_control_reg[c];
        quh_pkg::OFS_TRIG: rd_reg = s.trig[c];
        quh_pkg::OFS_CST:  rd_reg = {2'h0, ch[c].tx_free != 8'h00,
                                     ch[c].rx_count != 8'h00, ch[c].irq_src};
        default:           rd_reg = 8'h00;
      endcase
    end
  endfunction : rd_reg

  // write decode; unmapped indexes are ignored
  function automatic quh_pkg::quh_state_t wr_reg(input quh_pkg::quh_state_t s,
                                                 input logic [4:0] idx,
                                                 input logic [7:0] v);
    logic [1:0] c;
    c = idx[4:3];
    wr_reg = s;
    if (idx == quh_pkg::IDX_MSK) begin
      wr_reg.msk = v;
    end else if (idx[2] == 1'b0) begin
      case (idx[2:0])
        quh_pkg::OFS_IER:  wr_reg.irq_enable_reg[c] = v;
        quh_pkg::OFS_MCR:  wr_reg.modem_control_reg[c] = v;
        quh_pkg::OFS_TRIG: wr_reg.trig[c] = v;
        default:           wr_reg = s;
      endcase
    end
  endfunction : wr_reg

  // receive threshold: a trigger of zero behaves as one character
  function automatic logic [7:0] rx_thr(input logic [7:0] t);
    rx_thr = (t == 8'h00) ? 8'h01 : t;
  endfunction : rx_thr

  // reset pin polarity follows the strapped bus mode
  assign pin_rst    = q.mode_pc ? i_reset_pin : !i_reset_pin;
  assign clr        = !i_rst_n || pin_rst;
  assign music_rise = i_music_link_clock && !q.music_prev;

  // per-channel status terms
  always_comb begin
    for (int c = 0; c < quh_pkg::NCH; c++) begin
      svc[c]   = |(i_chan[c].irq_src & q.irq_enable_reg[c][3:0]);
      rx_av[c] = i_chan[c].rx_count != 8'h00;
      tx_sp[c] = i_chan[c].tx_free != 8'h00;
      ir_en[c] = q.modem_control_reg[c][quh_pkg::MCR_IR_SEL] && i_chan[c].tx_enable;
    end
  end

  // next state
  always_comb begin
    logic       evt_clr;
    logic [4:0] widx;
    logic       fall;
    logic       rise;
    evt_clr = 1'b0;
    widx    = i_wb_adr[6:2];
    fall    = q.strobe_prev && !i_rw_strobe;
    rise    = !q.strobe_prev && i_rw_strobe;
    d = q;
    d.strobe_prev = i_rw_strobe;
    d.music_prev  = i_music_link_clock;

    // wishbone: one wait state, ack for exactly one cycle, upper bits of
    // the address beyond the map read as zero
    d.wb_ack = i_wb_cyc && i_wb_stb && !q.wb_ack;
    if (d.wb_ack) begin
      if (i_wb_we) begin
        d.wb_dat = 8'h00;
        if (i_wb_sel[0] && i_wb_adr[7] == 1'b0) begin
          d = wr_reg(d, widx, i_wb_dat[7:0]);
        end
      end else begin
        d.wb_dat = (i_wb_adr[7] == 1'b0) ? rd_reg(q, i_chan, widx) : 8'h00;
        evt_clr  = (i_wb_adr[7] == 1'b0) && (widx == quh_pkg::IDX_EVT);
      end
    end

    // processor strobe port, live only in processor bus mode
    if (!q.mode_pc) begin
      case (q.sst)
        quh_pkg::ST_IDLE, quh_pkg::ST_DRIVE: begin
          if (fall && !i_cs_n) begin
            d = wr_reg(d, i_reg_address, i_cpu_data);
            d.sst = quh_pkg::ST_LOW;
          end else if (i_cs_n) begin
            d.sst = quh_pkg::ST_IDLE;
          end
        end
        quh_pkg::ST_LOW: begin
          if (i_cs_n) begin
            d.sst = quh_pkg::ST_IDLE;
          end else if (rise) begin
            d.pdata = rd_reg(q, i_chan, i_reg_address);
            evt_clr = evt_clr || (i_reg_address == quh_pkg::IDX_EVT);
            d.sst   = quh_pkg::ST_DRIVE;
          end
        end
        default: d.sst = quh_pkg::ST_IDLE;
      endcase
    end else begin
      d.sst = quh_pkg::ST_IDLE;
    end

    // sticky events: new data ready or new transmit room; set beats clear
    d.rx_prev = rx_av;
    d.tx_prev = tx_sp;
    d.evt = (q.evt & ~{8{evt_clr}}) | {tx_sp & ~q.tx_prev, rx_av & ~q.rx_prev};
    d.irq = |(d.evt & d.msk);

    // interrupt pins
    d.irq_any_n = q.mode_pc || !(|svc);
    for (int c = 0; c < quh_pkg::NCH; c++) begin
      d.irq_chan[c] = q.mode_pc && q.modem_control_reg[c][quh_pkg::MCR_IRQ_OE] && svc[c];
    end

    // ready pins
    d.rx_any_n = !(|rx_av);
    d.tx_any_n = !(|tx_sp);
    for (int c = 0; c < quh_pkg::NCH; c++) begin
      d.rx_chan_n[c] = !(i_chan[c].rx_count >= rx_thr(q.trig[c]));
    end

    // serial pins: music mode moves data on the music clock edge,
    // infrared mode parks the modem line at mark
    for (int c = 0; c < quh_pkg::NCH; c++) begin
      d.rx_en[c] = 1'b1;
      if (q.modem_control_reg[c][quh_pkg::MCR_MUSIC]) begin
        if (music_rise) begin
          d.ser_tx[c]   = i_chan[c].music_tx;
          d.music_rx[c] = i_serial_rx_in[c];
        end
      end else begin
        d.ser_tx[c] = !i_chan[c].tx_enable || q.modem_control_reg[c][quh_pkg::MCR_IR_SEL]
                      || i_chan[c].tx_bit;
      end
    end

    // reset from either source; the strap is caught while i_rst_n is low
    if (clr) begin
      d.mode_pc = i_rst_n ? q.mode_pc : i_bus_mode_pc;
      d.irq_enable_reg     = {4{quh_pkg::IER_RST}};
      d.modem_control_reg     = {4{quh_pkg::MCR_RST}};
      d.trig    = {4{quh_pkg::TRIG_RST}};
      d.evt     = quh_pkg::EVT_RST;
      d.msk     = quh_pkg::MSK_RST;
      d.rx_prev = 4'h0;
      d.tx_prev = 4'h0;
      d.wb_dat  = 8'h00;
      d.sst     = quh_pkg::ST_IDLE;
      d.pdata   = 8'h00;
      d.irq     = 1'b0;
      d.irq_any_n = 1'b1;
      d.irq_chan  = 4'h0;
      d.rx_any_n  = 1'b1;
      d.rx_chan_n = 4'hf;
      d.tx_any_n  = 1'b1;
      d.ser_tx    = 4'hf;
      d.rx_en     = 4'h0;
      d.music_rx  = 4'h0;
      // a pin reset must not swallow the bus handshake
      d.wb_ack    = i_rst_n && d.wb_ack;
    end
  end

  always_ff @(posedge i_mclk) begin
    q <= d;
  end

  // infrared encoders, one per channel
  for (genvar g = 0; g < quh_pkg::NCH; g++) begin : g_ir
    quh_ir_enc u_ir (
      .i_mclk   (i_mclk),
      .i_clr    (clr),
      .i_tick16 (i_tick16),
      .i_bit    (i_chan[g].tx_bit),
      .i_enable (ir_en[g]),
      .o_ir     (o_infrared_tx_out[g])
    );
  end

  // outputs straight from the state flops
  assign o_wb_dat          = {24'h000000, q.wb_dat};
  assign o_wb_ack          = q.wb_ack;
  assign o_irq             = q.irq;
  assign o_cpu_data        = q.pdata;
  assign o_cpu_data_oe     = q.sst[2]; // one-hot: the drive state's own flop
  assign o_music_rx        = q.music_rx;
  assign o_irq_any_n       = q.irq_any_n;
  assign o_irq_chan        = q.irq_chan;
  assign o_rx_ready_any_n  = q.rx_any_n;
  assign o_rx_ready_chan_n = q.rx_chan_n;
  assign o_tx_ready_any_n  = q.tx_any_n;
  assign o_serial_tx_out   = q.ser_tx;
  assign o_rx_enable       = q.rx_en;

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_strobe_wr;
    !clr && !q.mode_pc && q.strobe_prev && !i_rw_strobe && !i_cs_n
    && !o_wb_ack && !(i_wb_cyc && i_wb_stb) && i_reg_address == quh_pkg::IDX_MSK;
  endsequence
  sequence s_strobe_rd;
    !clr && !q.mode_pc && q.sst == quh_pkg::ST_LOW && !i_cs_n
    && !q.strobe_prev && i_rw_strobe;
  endsequence

  chk_irq_merge: assert property ((!clr && !q.mode_pc && |svc) |=> !o_irq_any_n)
    else $error("combined interrupt not asserted");
  chk_irq_quiet: assert property ((!clr && !(|svc)) |=> o_irq_any_n)
    else $error("combined interrupt without enabled source");
  chk_ir_idle: assert property ((clr || ir_en == 4'h0) |=> o_infrared_tx_out == 4'h0)
    else $error("infrared output not low");
  chk_ir_modem: assert property ((!clr && q.modem_control_reg[0][6] && !q.modem_control_reg[0][7]) |=> o_serial_tx_out[0])
    else $error("modem line not parked in infrared mode");
  chk_reset_out: assert property (clr |=> o_rx_enable == 4'h0 && o_serial_tx_out == 4'hf
                                   && o_rx_ready_any_n && o_tx_ready_any_n)
    else $error("outputs not in reset state");
  chk_strobe_wr: assert property (s_strobe_wr |=> q.msk == $past(i_cpu_data))
    else $error("strobe write lost");
  chk_strobe_rd: assert property (s_strobe_rd |=> o_cpu_data_oe ##0 o_cpu_data == $past(
                                  rd_reg(q, i_chan, i_reg_address)))
    else $error("strobe read not driven");
  chk_rx_any: assert property (!clr |=> o_rx_ready_any_n == $past(!(|rx_av)))
    else $error("combined receive ready wrong");
  chk_rx_chan: assert property ((!clr && i_chan[0].rx_count == 8'h00) |=> o_rx_ready_chan_n[0])
    else $error("channel receive ready low while empty");
  chk_tx_any: assert property (!clr |=> o_tx_ready_any_n == $past(!(|tx_sp)))
    else $error("combined transmit ready wrong");
  chk_irq_chan: assert property ((!clr && !q.modem_control_reg[0][3]) |=> !o_irq_chan[0])
    else $error("channel interrupt not gated");

  // pc mode: a high reset pin silences the interrupt pins an edge later
  chk_pc_pin_rst: assert property ((q.mode_pc && i_reset_pin)
                                   |=> o_irq_chan == 4'h0 && !o_irq)
    else $error("pc mode pin reset ignored");
  // processor mode: the same pin resets while it is low
  chk_cpu_pin_rst: assert property ((!q.mode_pc && !i_reset_pin)
                                    |=> o_irq_any_n && !o_cpu_data_oe)
    else $error("processor mode pin reset ignored");
  // music mode takes the receive pin only at a music clock rise
  chk_music_rx: assert property ((!clr && music_rise
                                  && q.modem_control_reg[3][quh_pkg::MCR_MUSIC])
                                 |=> o_music_rx[3] == $past(i_serial_rx_in[3]))
    else $error("music receive sample lost");
  // a channel at or above its trigger level reports ready
  chk_rx_chan_low: assert property ((!clr && q.trig[2] != 8'h00
                                     && i_chan[2].rx_count >= q.trig[2])
                                    |=> !o_rx_ready_chan_n[2])
    else $error("channel receive ready not low");
  // one free transmit slot anywhere pulls the combined pin low
  chk_tx_any_low: assert property ((!clr && i_chan[1].tx_free != 8'h00)
                                   |=> !o_tx_ready_any_n)
    else $error("combined transmit ready not low");
  // the strap is caught only under system reset, so bus style never moves at run time
  chk_strap_hold: assert property (i_rst_n |=> $stable(q.mode_pc))
    else $error("bus style changed outside reset");
  // an acknowledge lasts one cycle, even while its request still stands
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("bus acknowledge longer than one cycle");
  // a new character sets its event bit, even against a clearing read
  sequence s_rx_new;
    !clr && rx_av[2] && !q.rx_prev[2];
  endsequence
  chk_evt_set: assert property (s_rx_new |=> q.evt[2])
    else $error("receive event not recorded");
endmodule : quh_top

//--- design/quh_pkg.sv
// shared constants and types for the quad uart host status block
package quh_pkg;
  localparam int NCH = 4;
  // register index = wishbone byte address / 4; channel in index[4:3]
  localparam logic [2:0] OFS_IER  = 3'h0;
  localparam logic [2:0] OFS_MCR  = 3'h1;
  localparam logic [2:0] OFS_TRIG = 3'h2;
  localparam logic [2:0] OFS_CST  = 3'h3;
  localparam logic [4:0] IDX_EVT  = 5'h04;
  localparam logic [4:0] IDX_MSK  = 5'h05;
  // modem_control_reg bit positions
  localparam int MCR_IRQ_OE = 3;
  localparam int MCR_IR_SEL = 6;
  localparam int MCR_MUSIC  = 7;
  // values after reset
  localparam logic [7:0] IER_RST  = 8'h00;
  localparam logic [7:0] MCR_RST  = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'h01;
  localparam logic [7:0] MSK_RST  = 8'h00;
  localparam logic [7:0] EVT_RST  = 8'h00;
  // infrared pulse: 3 of 16 sub-bit ticks, centred in the bit
  localparam logic [3:0] IR_PULSE_LO = 4'h7;
  localparam logic [3:0] IR_PULSE_HI = 4'h9;
  // processor strobe port states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LOW   = 3'b010,
    ST_DRIVE = 3'b100
  } quh_strobe_t;
  // per-channel signals from the serial engine
  typedef struct packed {
    logic [3:0] irq_src;
    logic [7:0] rx_count;
    logic [7:0] tx_free;
    logic       tx_bit;
    logic       tx_enable;
    logic       music_tx;
  } quh_chan_in_t;
  // whole state of the top module
  typedef struct packed {
    logic            mode_pc;
    logic [3:0][7:0] irq_enable_reg;
    logic [3:0][7:0] modem_control_reg;
    logic [3:0][7:0] trig;
    logic [7:0]      evt;
    logic [7:0]      msk;
    logic [3:0]      rx_prev;
    logic [3:0]      tx_prev;
    logic            wb_ack;
    logic [7:0]      wb_dat;
    quh_strobe_t     sst;
    logic            strobe_prev;
    logic [7:0]      pdata;
    logic            music_prev;
    logic            irq;
    logic            irq_any_n;
    logic [3:0]      irq_chan;
    logic            rx_any_n;
    logic [3:0]      rx_chan_n;
    logic            tx_any_n;
    logic [3:0]      ser_tx;
    logic [3:0]      rx_en;
    logic [3:0]      music_rx;
  } quh_state_t;
  // state of one infrared encoder
  typedef struct packed {
    logic [3:0] cnt;
    logic       bit_prev;
    logic       ir;
  } quh_ir_state_t;
endpackage : quh_pkg

//--- design/quh_ir_enc.sv
// infrared pulse encoder for one channel's framed serial stream
`timescale 1ns/1ns
module quh_ir_enc (
  input  wire logic i_mclk,
  input  wire logic i_clr,
  input  wire logic i_tick16,
  input  wire logic i_bit,
  input  wire logic i_enable,
  output logic      o_ir
);
  quh_pkg::quh_ir_state_t q, d;

  // sub-bit counter restarts on the start-bit edge so pulses stay centred
  always_comb begin
    d = q;
    d.bit_prev = i_bit;
    if (q.bit_prev && !i_bit) begin
      d.cnt = 4'h0;
    end else if (i_tick16) begin
      d.cnt = q.cnt + 4'h1;
    end
    // a zero bit of the frame becomes a short high pulse, a one stays low
    d.ir = i_enable && !i_bit && (q.cnt >= quh_pkg::IR_PULSE_LO)
           && (q.cnt <= quh_pkg::IR_PULSE_HI);
    // held low in reset, when idle and when the transmitter is off
    if (i_clr) begin
      d.cnt      = 4'h0;
      d.bit_prev = 1'b1;
      d.ir       = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    q <= d;
  end

  assign o_ir = q.ir;
endmodule : quh_ir_enc

//--- verification/quh_cpu_model.sv
// processor bus model that works the combined read/write strobe port
`timescale 1ns/1ns
module quh_cpu_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_cpu_data,
  input  wire logic       i_cpu_data_oe,
  output logic            o_cs_n,
  output logic            o_rw_strobe,
  output logic [4:0]      o_reg_address,
  output logic [7:0]      o_cpu_data
);
  // idle bus: deselected, strobe high
  initial begin
    o_cs_n        = 1'b1;
    o_rw_strobe   = 1'b1;
    o_reg_address = 5'h00;
    o_cpu_data    = 8'h5a;
  end

  // one cycle: the falling strobe writes wd, the rising strobe reads the register back
  task automatic xfer(input logic [4:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge i_mclk);
    o_cs_n        <= 1'b0;
    o_reg_address <= idx;
    o_cpu_data    <= wd;
    @(posedge i_mclk);
    o_rw_strobe <= 1'b0;
    repeat (2) @(posedge i_mclk);
    o_rw_strobe <= 1'b1;
    // released lines show a changed pattern, never the byte just written
    o_cpu_data  <= ~wd;
    do begin
      @(posedge i_mclk);
      n++;
    end while (i_cpu_data_oe !== 1'b1 && n < 8);
    rd = i_cpu_data;
    o_cs_n <= 1'b1;
  endtask : xfer
endmodule : quh_cpu_model

//--- verification/quh_top_tb.sv
// self-checking bench for the quad uart host status pins
`timescale 1ns/1ns
module quh_top_tb;
  logic                        i_mclk, i_rst_n, i_bus_mode_pc, i_reset_pin, i_tick16;
  logic                        i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_irq, i_cs_n;
  logic                        i_rw_strobe, o_cpu_data_oe, i_music_link_clock, o_irq_any_n;
  logic                        o_rx_ready_any_n, o_tx_ready_any_n;
  logic [7:0]                  i_wb_adr, i_cpu_data, o_cpu_data, rd8;
  logic [3:0]                  i_wb_sel, o_irq_chan, o_rx_ready_chan_n, o_serial_tx_out;
  logic [3:0]                  o_rx_enable, o_infrared_tx_out, o_music_rx, i_serial_rx_in;
  logic [31:0]                 i_wb_dat, o_wb_dat;
  logic [4:0]                  i_reg_address;
  logic                        park;
  quh_pkg::quh_chan_in_t [3:0] i_chan;
  int                          errors, samples_checked, cycles, hi;

  quh_top dut (.i_mclk, .i_rst_n, .i_bus_mode_pc, .i_reset_pin, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_irq, .i_cs_n,
    .i_rw_strobe, .i_reg_address, .i_cpu_data, .o_cpu_data, .o_cpu_data_oe, .i_chan,
    .i_tick16, .i_music_link_clock, .i_serial_rx_in, .o_music_rx, .o_irq_any_n, .o_irq_chan,
    .o_rx_ready_any_n, .o_rx_ready_chan_n, .o_tx_ready_any_n, .o_serial_tx_out,
    .o_rx_enable, .o_infrared_tx_out);

  quh_cpu_model cpu (.i_mclk, .i_cpu_data(o_cpu_data), .i_cpu_data_oe(o_cpu_data_oe),
    .o_cs_n(i_cs_n), .o_rw_strobe(i_rw_strobe), .o_reg_address(i_reg_address),
    .o_cpu_data(i_cpu_data));

  // 10 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // step n edges, then look once the registered outputs have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : wait_cyc

  // classic single wishbone cycle, holds the request until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    @(posedge i_mclk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= w;
    i_wb_adr <= a;
    i_wb_dat <= {24'h000000, d};
    // no bound here: the cycle ceiling ends a wait that never gets its answer
    do begin
      @(posedge i_mclk);
    end while (o_wb_ack !== 1'b1);
    r = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
  endtask : wb

  function automatic logic [7:0] ra(input logic [1:0] c, input logic [2:0] o);
    return {1'b0, c, o, 2'b00};
  endfunction : ra

  // pin levels are inactive for the strap given; the system reset is held 6 cycles
  task automatic do_reset(input logic pc);
    @(posedge i_mclk);
    i_rst_n       <= 1'b0;
    i_bus_mode_pc <= pc;
    i_reset_pin   <= ~pc;
    wait_cyc(5);
    check("irq_any_n", 8'h01, {7'h00, o_irq_any_n});
    check("ready_n", 8'h03, {6'h00, o_rx_ready_any_n, o_tx_ready_any_n});
    check("ser_tx", 8'h0f, {4'h0, o_serial_tx_out});
    check("rx_en", 8'h00, {4'h0, o_rx_enable});
    check("ir_tx", 8'h00, {4'h0, o_infrared_tx_out});
    @(posedge i_mclk);
    i_rst_n <= 1'b1;
    wait_cyc(2);
    check("rx_en", 8'h0f, {4'h0, o_rx_enable});
  endtask : do_reset

  // infrared output over one low bit, tick every cycle; counts high cycles
  task automatic ir_bit(input logic en);
    i_chan[0].tx_enable <= en;
    hi = 0;
    for (int i = 0; i < 24; i++) begin
      @(posedge i_mclk);
      if (i == 0) i_chan[0].tx_bit <= 1'b0;
      if (i == 16) i_chan[0].tx_bit <= 1'b1;
      #1;
      if (o_infrared_tx_out[0] === 1'b1) hi++;
      if (i == 8) park = o_serial_tx_out[0];
    end
  endtask : ir_bit

  initial begin
    {i_rst_n, i_bus_mode_pc, i_reset_pin, i_wb_cyc, i_wb_stb, i_wb_we} = 6'h01;
    {i_tick16, i_music_link_clock, i_serial_rx_in, i_wb_adr} = 14'h0000;
    i_wb_sel = 4'h1;
    i_wb_dat = 32'h00000000;
    i_chan   = '0;
    do_reset(1'b0);
    wb(1'b0, ra(2'h0, quh_pkg::OFS_MCR), 8'h00, rd8);
    check("mcr_rst", quh_pkg::MCR_RST, rd8);
    wb(1'b0, ra(2'h0, quh_pkg::OFS_TRIG), 8'h00, rd8);
    check("trig_rst", quh_pkg::TRIG_RST, rd8);
    wb(1'b1, 8'h80, 8'hff, rd8);
    wb(1'b0, 8'h80, 8'h00, rd8);
    check("unmapped", 8'h00, rd8);
    // receive ready: one character on channel 2, then a trigger above it
    @(posedge i_mclk);
    i_chan[2].rx_count <= 8'h01;
    wait_cyc(2);
    check("rx_any_n", 8'h00, {7'h00, o_rx_ready_any_n});
    check("rx_chan_n", 8'h0b, {4'h0, o_rx_ready_chan_n});
    wb(1'b1, ra(2'h2, quh_pkg::OFS_TRIG), 8'h03, rd8);
    wait_cyc(2);
    check("rx_chan_n", 8'h0f, {4'h0, o_rx_ready_chan_n});
    check("rx_any_n", 8'h00, {7'h00, o_rx_ready_any_n});
    // sticky event masked, then unmasked, then cleared by reading
    check("irq", 8'h00, {7'h00, o_irq});
    wb(1'b1, {1'b0, quh_pkg::IDX_MSK, 2'b00}, 8'h04, rd8);
    wait_cyc(2);
    check("irq", 8'h01, {7'h00, o_irq});
    wb(1'b0, {1'b0, quh_pkg::IDX_EVT, 2'b00}, 8'h00, rd8);
    check("evt", 8'h04, rd8);
    wait_cyc(2);
    check("irq", 8'h00, {7'h00, o_irq});
    // transmit ready: no room anywhere, then one free slot
    check("tx_any_n", 8'h01, {7'h00, o_tx_ready_any_n});
    @(posedge i_mclk);
    i_chan[1].tx_free <= 8'h01;
    wait_cyc(2);
    check("tx_any_n", 8'h00, {7'h00, o_tx_ready_any_n});
    // combined interrupt gated by the enable bits, written over the strobe port
    @(posedge i_mclk);
    i_chan[1].irq_src <= 4'h2;
    wait_cyc(2);
    check("irq_any_n", 8'h01, {7'h00, o_irq_any_n});
    cpu.xfer(5'h08, 8'h02, rd8);
    check("cpu_rd", 8'h02, rd8);
    wait_cyc(2);
    check("irq_any_n", 8'h00, {7'h00, o_irq_any_n});
    check("irq_chan", 8'h00, {4'h0, o_irq_chan});
    cpu.xfer(5'h08, 8'h01, rd8);
    wait_cyc(2);
    check("irq_any_n", 8'h01, {7'h00, o_irq_any_n});
    wb(1'b0, ra(2'h1, quh_pkg::OFS_IER), 8'h00, rd8);
    check("ier1", 8'h01, rd8);
    // mask written over the strobe port lets the pending transmit event through
    cpu.xfer(quh_pkg::IDX_MSK, 8'h24, rd8);
    check("cpu_msk", 8'h24, rd8);
    wait_cyc(2);
    check("irq", 8'h01, {7'h00, o_irq});
    // infrared: silent while disabled, three ticks wide when enabled
    i_tick16 <= 1'b1;
    wb(1'b1, ra(2'h0, quh_pkg::OFS_MCR), 8'h40, rd8);
    ir_bit(1'b0);
    check("ir_off", 8'h00, hi[7:0]);
    ir_bit(1'b1);
    check("ir_pulse", 8'h03, hi[7:0]);
    check("ser_park", 8'h01, {7'h00, park});
    wb(1'b1, ra(2'h0, quh_pkg::OFS_MCR), 8'h00, rd8);
    ir_bit(1'b1);
    check("ser_modem", 8'h00, {7'h00, park});
    check("ir_modem", 8'h00, hi[7:0]);
    // music mode on channel 3
    wb(1'b1, ra(2'h3, quh_pkg::OFS_MCR), 8'h80, rd8);
    @(posedge i_mclk);
    i_serial_rx_in[3] <= 1'b1;
    @(posedge i_mclk);
    i_music_link_clock <= 1'b1;
    wait_cyc(3);
    check("music_rx", 8'h01, {7'h00, o_music_rx[3]});
    check("music_tx", 8'h00, {7'h00, o_serial_tx_out[3]});
    i_music_link_clock <= 1'b0;
    // processor-mode pin reset is active low
    i_reset_pin <= 1'b0;
    wait_cyc(2);
    check("pin_rst_en", 8'h00, {4'h0, o_rx_enable});
    check("pin_rst_ir", 8'h00, {4'h0, o_infrared_tx_out});
    i_reset_pin <= 1'b1;
    wait_cyc(2);
    wb(1'b0, ra(2'h3, quh_pkg::OFS_MCR), 8'h00, rd8);
    check("mcr3_rst", quh_pkg::MCR_RST, rd8);
    // pc mode: per-channel interrupts, strobe port ignored, pin reset active high
    do_reset(1'b1);
    wb(1'b1, ra(2'h1, quh_pkg::OFS_IER), 8'h02, rd8);
    wb(1'b1, ra(2'h1, quh_pkg::OFS_MCR), 8'h08, rd8);
    wait_cyc(2);
    check("irq_chan", 8'h02, {4'h0, o_irq_chan});
    check("irq_any_n", 8'h01, {7'h00, o_irq_any_n});
    cpu.xfer(5'h00, 8'h0f, rd8);
    wb(1'b0, ra(2'h0, quh_pkg::OFS_IER), 8'h00, rd8);
    check("ier0", quh_pkg::IER_RST, rd8);
    i_reset_pin <= 1'b1;
    wait_cyc(2);
    check("pc_rst_irq", 8'h00, {4'h0, o_irq_chan});
    check("pc_rst_en", 8'h00, {4'h0, o_rx_enable});
    test_done();
  end
endmodule : quh_top_tb
